// File: bwt_cpu_model.sv
// cpu core model issuing held bus cycles
`default_nettype none
module bwt_cpu_model
(
  input wire logic clk,
  input wire logic cpu_ack,
  output logic cpu_req,
  output logic cpu_we,
  output logic cpu_word,
  output logic [23:0] cpu_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cpu_req = 1'b0;
    cpu_we = 1'b0;
    cpu_word = 1'b0;
    cpu_addr = 24'h00_0000;
  end
  task automatic access(input logic [23:0] a, input logic we, input logic wd, output int n);
    n = 0;
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_word <= wd;
    cpu_addr <= a;
    do @(posedge clk) n++; while (cpu_ack !== 1'b1 && n < 64);
    // released lines must not look valid
    cpu_req <= 1'b0;
    cpu_addr <= ~a;
    cpu_we <= ~we;
    cpu_word <= ~wd;
  endtask : access
endmodule : bwt_cpu_model
`default_nettype wire

// File: bwt_pkg.sv
// constants, field layout and types of the bus cycle timing unit
`default_nettype none
package bwt_pkg;
  // ===========================================================
  // register offsets (wishbone byte addresses)
  localparam logic [7:0] OFS_BUS_MODE = 8'h00;
  localparam logic [7:0] OFS_IO_CFG = 8'h04;
  localparam logic [7:0] OFS_FLASH_CFG = 8'h08;
  localparam logic [7:0] OFS_Z2_CFG = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // ===========================================================
  // reset values
  localparam logic [7:0] RST_BUS_MODE = 8'h07;
  localparam logic [15:0] RST_ZONE_CFG = 16'h069f;
  // ===========================================================
  // zone timing field positions, plus the bus mode early write bit
  localparam int F_WAIT_LO = 0;
  localparam int F_HOLD_LO = 3;
  localparam int F_BURST_EN = 5;
  localparam int F_BURST_WAIT = 6;
  localparam int F_WIDTH = 7;
  localparam int F_POST_IDLE = 9;
  localparam int F_PRE_IDLE = 10;
  localparam int F_FAST_READ = 11;
  localparam int F_EARLY_WRITE = 0;
  // ===========================================================
  // cpu address ranges, inclusive
  localparam logic [23:0] FLASH_PGM_LO = 24'h00_0000;
  localparam logic [23:0] FLASH_PGM_HI = 24'h03_ffff;
  localparam logic [23:0] FLASH_DAT_LO = 24'h0e_0000;
  localparam logic [23:0] FLASH_DAT_HI = 24'h0e_1fff;
  localparam logic [23:0] RAM0_LO = 24'h0e_8000;
  localparam logic [23:0] RAM0_HI = 24'h0e_91ff;
  localparam logic [23:0] RAM1_LO = 24'h0e_c000;
  localparam logic [23:0] RAM1_HI = 24'h0e_ebff;
  localparam logic [23:0] PERI0_LO = 24'h0e_f000;
  localparam logic [23:0] PERI0_HI = 24'h0e_f1ff;
  localparam logic [23:0] PERI1_LO = 24'hff_0000;
  localparam logic [23:0] PERI1_HI = 24'hff_fbff;
  localparam logic [23:0] IOZ_LO = 24'hff_fb00;
  localparam logic [23:0] IOZ_HI = 24'hff_fbff;
  // ===========================================================
  // clock figures
  localparam int CLK_HZ = 25_000_000;
  localparam int FAST_READ_MAX_HZ = 24_000_000;
  localparam logic [5:0] CNT_ONE = 6'h01;
  localparam logic [5:0] PERI_ACC_CYC = 6'h02;
  localparam logic [5:0] PERI_IDLE_CYC = 6'h01;
  // ===========================================================
  // types
  typedef enum logic [2:0] {
    ZN_RAM = 3'h0,
    ZN_FLASH = 3'h1,
    ZN_PERIPH = 3'h2,
    ZN_IO = 3'h3,
    ZN_ZONE2 = 3'h4
  } bwt_zone_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } bwt_state_e;
endpackage : bwt_pkg
`default_nettype wire

// File: bwt_tb.sv
// self-checking bench for the bus cycle timing unit
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %0t mismatch", $time); end end
module testbench
  import bwt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cpu_req, cpu_we, cpu_word, cpu_ack;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [23:0] cpu_addr;
  logic [15:0] cfg [3];
  logic [7:0] bm;
  int fails, checked, cyc_n, pz, pp, n, k, s;
  logic [23:0] bases [8] = '{FLASH_PGM_LO, FLASH_DAT_LO, RAM0_LO, RAM1_LO, PERI0_LO, PERI1_LO, IOZ_LO, 24'h10_0000};
  bwt_timing bwt_timing_inst (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_word(cpu_word), .cpu_addr(cpu_addr), .cpu_ack(cpu_ack),
    .idle_cycle(), .internal_wait_cycle(), .burst_wait_cycle(), .hold_cycle(), .zone2_select_out());
  bwt_cpu_model bwt_cpu_model_inst (.clk(clk), .cpu_ack(cpu_ack), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_word(cpu_word), .cpu_addr(cpu_addr));
  // ==========================================================
  // bus and reference tasks
  task automatic wb_xfer(input logic [7:0] a, input logic we, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk) t++; while (wb_ack_o !== 1'b1 && t < 20);
    if (wb_ack_o !== 1'b1)
      fails++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer
  function automatic int ref_cycles(input logic [23:0] a, input logic we, input logic wd);
    int z, acc, hd, bu, idl;
    logic [15:0] c;
    z = 4;
    if ((a >= RAM0_LO && a <= RAM0_HI) || (a >= RAM1_LO && a <= RAM1_HI)) z = 0;
    else if (a <= FLASH_PGM_HI || (a >= FLASH_DAT_LO && a <= FLASH_DAT_HI)) z = 1;
    else if (a >= IOZ_LO && a <= IOZ_HI) z = 3;
    else if ((a >= PERI0_LO && a <= PERI0_HI) || (a >= PERI1_LO && a <= PERI1_HI)) z = 2;
    c = (z == 1) ? cfg[1] : (z == 3) ? cfg[0] : cfg[2];
    acc = (we && z == 1) ? (c[11] ? 2 : 1 + c[2:0] + (bm[0] ? 2 : 1)) : 2 + c[2:0];
    hd = (we && z == 1 && c[11]) ? 0 : c[4:3];
    bu = 0;
    if (!we && c[11])
    begin
      acc = 1;
      hd = 0;
    end
    else if (!we && wd && !c[7] && z > 2)
    begin
      bu = c[5] ? 1 + c[6] : 0;
      acc = c[5] ? acc : 2 * acc;
      hd = c[5] ? hd : 2 * hd;
    end
    if (z == 0 || z == 2)
    begin
      acc = (z == 0) ? 1 : 2;
      hd = 0;
      bu = 0;
    end
    // idle only on zone change, peripherals always one
    idl = ((z == pz) ? 0 : pp + ((z == 1 || z > 2) ? c[10] : 0)) + ((z == 2) ? 1 : 0);
    pp = (z == 1 || z > 2) ? c[9] : 0;
    pz = z;
    return idl + acc + bu + hd;
  endfunction : ref_cycles
  task automatic end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // clock, timeout, sequence
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 30000)
    begin
      fails++;
      end_of_test();
    end
  end
  initial
  begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    s = $urandom(32'h228c_6f38);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    bm = RST_BUS_MODE;
    wb_xfer(OFS_BUS_MODE, 1'b0, 32'h0);
    `CHK(q, {24'h00_0000, RST_BUS_MODE})
    for (k = 0; k < 3; k++)
    begin
      cfg[k] = RST_ZONE_CFG;
      wb_xfer(OFS_IO_CFG + 8'(4 * k), 1'b0, 32'h0);
      `CHK(q, {16'h0000, RST_ZONE_CFG})
    end
    // unmapped place takes no write
    wb_xfer(8'h14, 1'b1, 32'hffff_ffff);
    wb_xfer(8'h14, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0000)
    $display("reset test done");
    pz = 0;
    pp = 0;
    for (int i = 0; i < 90; i++)
    begin
      if ($urandom % 3 == 0)
      begin
        k = $urandom % 3;
        cfg[k] = 16'($urandom);
        wb_xfer(OFS_IO_CFG + 8'(4 * k), 1'b1, {16'h0000, cfg[k]});
        wb_xfer(OFS_IO_CFG + 8'(4 * k), 1'b0, 32'h0);
        `CHK(q, {16'h0000, cfg[k]})
      end
      if ($urandom % 6 == 0)
      begin
        bm = 8'h06 | 8'($urandom % 2);
        wb_xfer(OFS_BUS_MODE, 1'b1, {24'h00_0000, bm});
      end
      s = $urandom;
      bwt_cpu_model_inst.access(bases[s[2:0]] + 24'(s[9:4]), s[3], s[10], n);
      `CHK(n, ref_cycles(bases[s[2:0]] + 24'(s[9:4]), s[3], s[10]))
    end
    // last finished cycle: not busy, its zone and post-idle kept
    wb_xfer(OFS_STATUS, 1'b0, 32'h0);
    `CHK(q[10:6], {1'b0, 3'(pz), 1'(pp)})
    $display("traffic test done");
    end_of_test();
  end
endmodule : testbench
`undef CHK
`default_nettype wire

// File: bwt_timing.sv
// bus cycle wait, hold, burst and idle timing unit with wishbone register slave
// Summary of operation
// - zone 2 timing register is 16-bit read/write, resets to 069Fh.
// - wait field adds zero to seven wait cycles, unused under fast read.
// - hold field gives zero to three hold cycles, unused under fast read.
// - burst enable makes word reads from byte-wide I/O and zone 2 zones a burst.
// - burst wait adds one cycle per burst read when burst is active.
// - width bit: 0 means byte-wide zone, 1 means word-wide zone.
// - fast read finishes in one cycle; normal reads take two or more.
// - post-idle adds one idle cycle after a cycle when zone changes.
// - pre-idle adds one idle cycle before a cycle when zone changes.
// - flash ranges take timing from flash zone register and access type.
// - fast flash reads take one cycle, clock limited to 24 MHz; CLK_HZ is 25 MHz here and nothing checks the limit.
// - normal flash read waits field plus one, holds hold field.
// - flash write under fast read: one wait, no hold.
// - flash write normal: field plus one late, plus two early; hold field.
// - on-chip RAM accesses complete in one cycle, after any post-idle cycle left by a zone change.
// - peripherals use one wait and one preliminary idle, no hold.
// - I/O zone range uses the I/O zone register timing.
// - zone 2 register times cycles that drive zone 2 select.
// - early write bit 0 of bus mode register, reset 07h.
`default_nettype none
module bwt_timing
  import bwt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_word,
  input wire logic [23:0] cpu_addr,
  output logic cpu_ack,
  output logic idle_cycle,
  output logic internal_wait_cycle,
  output logic burst_wait_cycle,
  output logic hold_cycle,
  output logic zone2_select_out
);

  // ===========================================================
  // address decode
  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic bwt_zone_e zone_of(input logic [23:0] a);
    // io zone sits inside the peripheral range, so it is tested before the peripheral ranges
    if (in_range(a, FLASH_PGM_LO, FLASH_PGM_HI) || in_range(a, FLASH_DAT_LO, FLASH_DAT_HI))
      zone_of = ZN_FLASH;
    else if (in_range(a, RAM0_LO, RAM0_HI) || in_range(a, RAM1_LO, RAM1_HI))
      zone_of = ZN_RAM;
    else if (in_range(a, IOZ_LO, IOZ_HI))
      zone_of = ZN_IO;
    else if (in_range(a, PERI0_LO, PERI0_HI) || in_range(a, PERI1_LO, PERI1_HI))
      zone_of = ZN_PERIPH;
    else
      zone_of = ZN_ZONE2;
  endfunction : zone_of

  // ===========================================================
  // registers
  logic [7:0] bus_write_mode_cfg_q;
  logic [15:0] io_zone_timing_cfg_q;
  logic [15:0] flash_zone_timing_cfg_q;
  logic [15:0] static_zone2_timing_cfg_q;
  logic wb_ack_q;
  logic [31:0] wb_dat_q;
  logic wb_take;
  logic wb_wr;

  assign wb_take = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  // write lands on the ack edge, while the master still holds its data
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_q;
  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      bus_write_mode_cfg_q <= RST_BUS_MODE;
    else if (wb_wr && wb_adr_i[7:2] == OFS_BUS_MODE[7:2] && wb_sel_i[0])
      bus_write_mode_cfg_q <= wb_dat_i[7:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      io_zone_timing_cfg_q <= RST_ZONE_CFG;
    else if (wb_wr && wb_adr_i[7:2] == OFS_IO_CFG[7:2])
    begin
      if (wb_sel_i[0])
        io_zone_timing_cfg_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        io_zone_timing_cfg_q[15:8] <= wb_dat_i[15:8];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      flash_zone_timing_cfg_q <= RST_ZONE_CFG;
    else if (wb_wr && wb_adr_i[7:2] == OFS_FLASH_CFG[7:2])
    begin
      if (wb_sel_i[0])
        flash_zone_timing_cfg_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        flash_zone_timing_cfg_q[15:8] <= wb_dat_i[15:8];
    end
  end

  // zone 2 register, full 16 bits kept
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      static_zone2_timing_cfg_q <= RST_ZONE_CFG;
    else if (wb_wr && wb_adr_i[7:2] == OFS_Z2_CFG[7:2])
    begin
      if (wb_sel_i[0])
        static_zone2_timing_cfg_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        static_zone2_timing_cfg_q[15:8] <= wb_dat_i[15:8];
    end
  end

  // ===========================================================
  // cycle planning
  bwt_state_e state_q;
  logic [5:0] pos_q;
  bwt_zone_e prev_zone_q;
  logic prev_post_q;
  logic [5:0] last_total_q;
  bwt_zone_e zone_q;
  logic [5:0] idle_q, acc_q, burst_q, hold_q;
  logic post_q;

  bwt_zone_e zone_d;
  logic [15:0] cfg;
  logic [5:0] idle_d, acc_d, burst_d, hold_d;
  logic post_d;
  logic [5:0] wt, hd;
  logic fast, rd;

  always_comb
  begin
    zone_d = zone_of(cpu_addr);
    rd = ~cpu_we;
    case (zone_d)
      ZN_FLASH: cfg = flash_zone_timing_cfg_q;
      ZN_IO: cfg = io_zone_timing_cfg_q;
      // zone 2 register times zone 2 select cycles
      ZN_ZONE2: cfg = static_zone2_timing_cfg_q;
      default: cfg = 16'h0000;
    endcase
    fast = cfg[F_FAST_READ];
    wt = {3'b000, cfg[F_WAIT_LO +: 3]};
    hd = {4'b0000, cfg[F_HOLD_LO +: 2]};
    idle_d = 6'h00;
    acc_d = CNT_ONE;
    burst_d = 6'h00;
    hold_d = 6'h00;
    post_d = cfg[F_POST_IDLE];
    case (zone_d)
      // ram is single cycle regardless of settings
      ZN_RAM: acc_d = CNT_ONE;
      ZN_FLASH:
      begin
        if (rd && fast)
          // fast flash read in one cycle
          acc_d = CNT_ONE;
        else if (rd)
        begin
          acc_d = 6'(CNT_ONE + wt + CNT_ONE);
          hold_d = hd;
        end
        else if (fast)
          acc_d = 6'(CNT_ONE + CNT_ONE);
        else
        begin
          // late adds one, early adds two
          acc_d = 6'(CNT_ONE + wt + (bus_write_mode_cfg_q[F_EARLY_WRITE] ? 6'h02 : CNT_ONE));
          hold_d = hd;
        end
      end
      ZN_PERIPH:
      begin
        // fixed one wait and preliminary idle
        acc_d = PERI_ACC_CYC;
        idle_d = PERI_IDLE_CYC;
        post_d = 1'b0;
      end
      default:
      begin
        if (rd && fast)
          acc_d = CNT_ONE;
        else
        begin
          // two-cycle base plus waits, then holds
          acc_d = 6'(PERI_ACC_CYC + wt);
          hold_d = hd;
          // byte-wide zone needs two transfers for a word read
          if (rd && cpu_word && !cfg[F_WIDTH])
          begin
            // burst fetches the second byte in one cycle, two with burst wait set
            if (cfg[F_BURST_EN])
              burst_d = 6'(CNT_ONE + {5'b00000, cfg[F_BURST_WAIT]});
            else
            begin
              acc_d = 6'(acc_d << 1);
              hold_d = 6'(hd << 1);
            end
          end
        end
      end
    endcase
    // extra idle only on a change of zone; peripherals always have one
    if (zone_d != prev_zone_q)
    begin
      // post-idle of previous plus pre-idle of current
      if (zone_d != ZN_PERIPH)
        idle_d = 6'({5'b00000, prev_post_q} + {5'b00000, cfg[F_PRE_IDLE]});
      else
        idle_d = 6'(PERI_IDLE_CYC + {5'b00000, prev_post_q});
    end
  end

  // ===========================================================
  // sequencer
  logic busy;
  logic active;
  logic [5:0] c_idle, c_acc, c_burst, c_hold, total, e_acc, e_burst;
  bwt_zone_e c_zone;
  logic c_post;
  logic last;

  // the first cycle is the request cycle itself, so a one-cycle access
  // acks combinationally; the cpu must hold address until ack
  assign busy = (state_q == ST_BUSY);
  assign active = busy | cpu_req;
  assign c_idle = busy ? idle_q : idle_d;
  assign c_acc = busy ? acc_q : acc_d;
  assign c_burst = busy ? burst_q : burst_d;
  assign c_hold = busy ? hold_q : hold_d;
  assign c_zone = busy ? zone_q : zone_d;
  assign c_post = busy ? post_q : post_d;
  assign e_acc = 6'(c_idle + c_acc);
  assign e_burst = 6'(e_acc + c_burst);
  assign total = 6'(e_burst + c_hold);
  assign last = (pos_q == 6'(total - CNT_ONE));

  assign cpu_ack = active & last;
  assign idle_cycle = active & (pos_q < c_idle);
  assign internal_wait_cycle = active & (pos_q > c_idle) & (pos_q < e_acc);
  assign burst_wait_cycle = active & (pos_q >= e_acc) & (pos_q < e_burst);
  assign hold_cycle = active & (pos_q >= e_burst);
  assign zone2_select_out = active & (c_zone == ZN_ZONE2) & ~idle_cycle;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      pos_q <= 6'h00;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (cpu_req && !last)
          begin
            state_q <= ST_BUSY;
            pos_q <= CNT_ONE;
          end
        end
        ST_BUSY:
        begin
          if (last)
          begin
            state_q <= ST_IDLE;
            pos_q <= 6'h00;
          end
          else
            pos_q <= 6'(pos_q + CNT_ONE);
        end
        default:
        begin
          state_q <= ST_IDLE;
          pos_q <= 6'h00;
        end
      endcase
    end
  end

  // plan frozen for the length of the cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idle_q <= 6'h00;
      acc_q <= 6'h00;
      burst_q <= 6'h00;
      hold_q <= 6'h00;
      zone_q <= ZN_RAM;
      post_q <= 1'b0;
    end
    else if (state_q == ST_IDLE && cpu_req)
    begin
      idle_q <= idle_d;
      acc_q <= acc_d;
      burst_q <= burst_d;
      hold_q <= hold_d;
      zone_q <= zone_d;
      post_q <= post_d;
    end
  end

  // remember zone of the finished cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_zone_q <= ZN_RAM;
      prev_post_q <= 1'b0;
      last_total_q <= 6'h00;
    end
    else if (cpu_ack)
    begin
      prev_zone_q <= c_zone;
      prev_post_q <= c_post;
      last_total_q <= total;
    end
  end

  // ===========================================================
  // wishbone read and ack
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_q <= wb_take;
      if (wb_take)
      begin
        // unmapped addresses ack with zero data
        case (wb_adr_i[7:2])
          OFS_BUS_MODE[7:2]: wb_dat_q <= {24'h00_0000, bus_write_mode_cfg_q};
          OFS_IO_CFG[7:2]: wb_dat_q <= {16'h0000, io_zone_timing_cfg_q};
          OFS_FLASH_CFG[7:2]: wb_dat_q <= {16'h0000, flash_zone_timing_cfg_q};
          OFS_Z2_CFG[7:2]: wb_dat_q <= {16'h0000, static_zone2_timing_cfg_q};
          OFS_STATUS[7:2]: wb_dat_q <= {21'h00_0000, busy, prev_zone_q, prev_post_q, last_total_q};
          default: wb_dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : bwt_timing
`default_nettype wire

// File: bwt_timing_asserts.sv
// port checker for the bus cycle timing unit
`default_nettype none
module bwt_timing_asserts
  import bwt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cpu_req,
  input wire logic [23:0] cpu_addr,
  input wire logic cpu_ack,
  input wire logic idle_cycle,
  input wire logic internal_wait_cycle,
  input wire logic burst_wait_cycle,
  input wire logic hold_cycle,
  input wire logic zone2_select_out
);
  // ==========================================================
  // zone decode
  logic ram;
  logic peri;
  logic z2;
  logic io;
  logic fl;
  assign ram = (cpu_addr >= RAM0_LO && cpu_addr <= RAM0_HI) || (cpu_addr >= RAM1_LO && cpu_addr <= RAM1_HI);
  assign io = cpu_addr >= IOZ_LO && cpu_addr <= IOZ_HI;
  assign fl = cpu_addr <= FLASH_PGM_HI || (cpu_addr >= FLASH_DAT_LO && cpu_addr <= FLASH_DAT_HI);
  assign peri = !io && ((cpu_addr >= PERI0_LO && cpu_addr <= PERI0_HI)
    || (cpu_addr >= PERI1_LO && cpu_addr <= PERI1_HI));
  assign z2 = !(ram || io || fl || peri);
  // ==========================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  AST_WB_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_RAM_ONE: assert property (cpu_req && ram && !idle_cycle |-> cpu_ack) else $error("ram slow");
  AST_RAM_NOWAIT: assert property (cpu_req && ram |-> !(internal_wait_cycle || hold_cycle || burst_wait_cycle))
    else $error("ram wait");
  AST_PERI_TWO: assert property (cpu_req && peri && !idle_cycle && !internal_wait_cycle
    |-> !cpu_ack ##1 (internal_wait_cycle && cpu_ack)) else $error("peri wait");
  AST_PERI_NOHOLD: assert property (cpu_req && peri |-> !hold_cycle && !burst_wait_cycle) else $error("peri hold");
  AST_Z2_SEL: assert property (cpu_req && !idle_cycle |-> zone2_select_out == z2) else $error("select");
  AST_IDLE_NOACK: assert property (idle_cycle |-> !cpu_ack && !internal_wait_cycle && !hold_cycle)
    else $error("idle");
  AST_HOLD_TAIL: assert property (hold_cycle && !cpu_ack |=> hold_cycle && !internal_wait_cycle)
    else $error("hold");
endmodule : bwt_timing_asserts
bind bwt_timing bwt_timing_asserts bwt_timing_asserts_inst (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_ack(cpu_ack),
  .idle_cycle(idle_cycle), .internal_wait_cycle(internal_wait_cycle), .burst_wait_cycle(burst_wait_cycle),
  .hold_cycle(hold_cycle), .zone2_select_out(zone2_select_out));
`default_nettype wire
